// [rtl/acq_pkg.sv]
// Constants shared by the acquisition trigger controller and its trigger synchroniser.
// Assumes a single 250 MHz system clock and a synchronous, active-high reset.
// Overview of operation
// RULE1: Normal mode integrates and sends spectra continuously.
// RULE2: Host selects normal, software or hardware trigger.
// RULE3: Software mode: level trigger, integration keeps running.
// RULE4: Each software trigger releases the gathered spectrum.
// RULE5: Held software trigger behaves like normal mode.
// RULE6: Software mode uses host integration time.
// RULE7: Software mode times integration from converter ticks.
// RULE8: Software trigger latency varies with period phase.
// RULE9: Hardware mode: edge trigger, idle until edge.
// RULE10: Hardware edge clears detector, then starts integrating.
// RULE11: Hardware integration fixed at fifty milliseconds.
// RULE12: Hardware mode sends spectrum, then idles again.
// RULE13: Trigger modes send nothing until a trigger.
// RULE14: Trigger device drives the dedicated trigger input.
// RULE15: Host sets other parameters in hardware mode.
// RULE16: Trigger input synchronised before any detection.
// RULE17: Trigger asserts high, rising edge by default.
package acq_pkg;

  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SW_TRIG = 2'h1;
  localparam logic [1:0] MODE_HW_TRIG = 2'h2;

  localparam int INTEG_W = 16;
  localparam int CNT_W = 24;

  localparam longint unsigned CLK_PERIOD_PS = 64'd4000;
  localparam longint unsigned HW_INTEG_TIME_MS = 64'd50;
  localparam longint unsigned PS_PER_MS = 64'd1000000000;
  localparam longint unsigned HW_INTEG_CYCLES_L = (HW_INTEG_TIME_MS * PS_PER_MS) / CLK_PERIOD_PS;

  localparam logic TRIG_ACTIVE_HIGH = 1'b1;
  localparam logic [2:0] SYNC_RESET = 3'h0;

endpackage

// [rtl/trig_if.sv]
// Interface carrying the conditioned trigger from the synchroniser to the controller.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface trig_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

// [rtl/trigger_sync.sv]
// Three-stage synchroniser and edge detector for the asynchronous trigger pin.
// Assumes the pin is unrelated to clk_sys.
`timescale 1ns/1ps
module trigger_sync
  import acq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic trigger_pin,
  trig_if.src trig
);

  logic [2:0] sync_reg;
  logic level_reg;
  logic rise_reg;

  // The first stage is read only by the second; a change counts once stages two and three agree.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_reg <= SYNC_RESET;
    end else begin
      sync_reg <= {sync_reg[1:0], trigger_pin ~^ TRIG_ACTIVE_HIGH}; // RULE16 RULE17
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      rise_reg <= 1'b0;
      if (sync_reg[1] == sync_reg[2]) begin
        level_reg <= sync_reg[2]; // RULE16
        rise_reg <= sync_reg[2] & ~level_reg; // RULE17
      end
    end
  end

  assign trig.level = level_reg;
  assign trig.rise = rise_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_sync_rise_level: assert property (rise_reg |-> level_reg) // RULE16
    else $error("Trigger rise without settled high level.");

endmodule // trigger_sync

// [rtl/acquisition_trigger_control.sv]
// Acquisition trigger controller: decides when the detector integrates and when a spectrum
// is handed to the host, in normal, software-trigger and hardware-trigger modes.
// Assumes mode_sel, integ_time and adc_tick come from logic on clk_sys; trigger_pin is async.
`timescale 1ns/1ps
module acquisition_trigger_control
  import acq_pkg::*;
#(
  parameter int unsigned HW_INTEG_CYCLES = int'(HW_INTEG_CYCLES_L)
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic trigger_pin,
  input wire logic [1:0] mode_sel,
  input wire logic [INTEG_W-1:0] integ_time,
  input wire logic adc_tick,
  output logic detector_clear,
  output logic integrating,
  output logic spectrum_send,
  output logic trigger_wait
);

  typedef enum logic [1:0] {ST_IDLE, ST_CLEAR, ST_INTEG} state_t;

  localparam logic [CNT_W-1:0] HW_LAST = CNT_W'(HW_INTEG_CYCLES - 1);
  localparam logic [CNT_W-1:0] HW_LEN = CNT_W'(HW_INTEG_CYCLES);

  trig_if trig ();

  trigger_sync u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .trigger_pin(trigger_pin),
    .trig(trig)
  );

  state_t state_reg;
  state_t state_next;
  logic [1:0] mode_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic pend_reg;
  logic detector_clear_reg;
  logic integrating_reg;
  logic spectrum_send_reg;
  logic trigger_wait_reg;

  logic mode_chg;
  logic is_sw;
  logic is_hw;
  logic [CNT_W-1:0] integ_last;
  logic free_done;
  logic hw_done;
  logic send_next;

  assign mode_chg = (mode_sel != mode_reg);
  assign is_sw = (mode_reg == MODE_SW_TRIG);
  assign is_hw = (mode_reg == MODE_HW_TRIG);

  // A zero integration time is taken as one converter tick.
  assign integ_last = (integ_time == '0) ? '0 : {{(CNT_W - INTEG_W){1'b0}}, integ_time - 1'b1};

  // Free-running periods are measured in converter ticks with the host time.
  assign free_done = (state_reg == ST_INTEG) && !is_hw && adc_tick
    && (cnt_reg >= integ_last); // RULE6 RULE7
  // Hardware periods are a fixed count of system clocks; integ_time is ignored.
  assign hw_done = (state_reg == ST_INTEG) && is_hw && (cnt_reg == HW_LAST); // RULE11

  // Normal mode sends every period; software mode only once a trigger was seen.
  assign send_next = !mode_chg && (hw_done
    || (free_done && (!is_sw || pend_reg || trig.level))); // RULE1 RULE4 RULE5 RULE13

  // Mode register follows the host selection; a change restarts acquisition from idle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_reg <= MODE_NORMAL;
    end else begin
      mode_reg <= mode_sel; // RULE2
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (is_hw) begin
          if (trig.rise) begin
            state_next = ST_CLEAR; // RULE9 RULE10
          end
        end else begin
          state_next = ST_INTEG; // RULE1 RULE3
        end
      end
      ST_CLEAR: begin
        state_next = ST_INTEG; // RULE10
      end
      ST_INTEG: begin
        if (hw_done) begin
          state_next = ST_IDLE; // RULE12
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (mode_chg) begin
      state_next = ST_IDLE; // RULE2
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Period counter: clock cycles in hardware mode, converter ticks otherwise.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (state_next != ST_INTEG || state_reg != ST_INTEG) begin
      cnt_reg <= '0;
    end else if (is_hw) begin
      cnt_reg <= cnt_reg + 1'b1; // RULE11
    end else if (adc_tick) begin
      cnt_reg <= free_done ? '0 : cnt_reg + 1'b1; // RULE7 RULE8
    end
  end

  // Software trigger is latched until the period end; a new level wins over the clear.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pend_reg <= 1'b0;
    end else if (mode_chg || !is_sw) begin
      pend_reg <= 1'b0; // RULE13
    end else if (trig.level) begin
      pend_reg <= 1'b1; // RULE3
    end else if (free_done) begin
      pend_reg <= 1'b0; // RULE4
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      detector_clear_reg <= 1'b0;
      integrating_reg <= 1'b0;
      spectrum_send_reg <= 1'b0;
      trigger_wait_reg <= 1'b0;
    end else begin
      detector_clear_reg <= (state_next == ST_CLEAR); // RULE10
      integrating_reg <= (state_next == ST_INTEG);
      spectrum_send_reg <= send_next;
      trigger_wait_reg <= (mode_sel == MODE_HW_TRIG) ? (state_next == ST_IDLE)
        : (mode_sel == MODE_SW_TRIG) && !pend_reg && !trig.level; // RULE13
    end
  end

  assign detector_clear = detector_clear_reg;
  assign integrating = integrating_reg;
  assign spectrum_send = spectrum_send_reg;
  assign trigger_wait = trigger_wait_reg;

  // Checking aid for the assertions only: length of the current run of integrating.
  logic [CNT_W-1:0] run_len_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      run_len_reg <= '0;
    end else if (integrating_reg) begin
      run_len_reg <= run_len_reg + 1'b1;
    end else begin
      run_len_reg <= '0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_normal_send_each: assert property ( // RULE1
    (mode_reg == MODE_NORMAL) && free_done && !mode_chg |=> spectrum_send)
    else $error("Normal mode period ended without a spectrum.");

  a_mode_change_restart: assert property ( // RULE2
    mode_chg |=> !integrating && !spectrum_send && !detector_clear)
    else $error("Mode change did not restart acquisition.");

  a_sw_free_running: assert property ( // RULE3
    is_sw && (state_reg == ST_IDLE) && !mode_chg |=> integrating)
    else $error("Software mode did not keep integrating.");

  a_sw_send_trigger: assert property ( // RULE4
    is_sw && spectrum_send |-> $past(pend_reg) || $past(trig.level))
    else $error("Software mode sent without a trigger.");

  a_sw_held_level: assert property ( // RULE5
    is_sw && trig.level && free_done && !mode_chg |=> spectrum_send)
    else $error("Held trigger did not send like normal mode.");

  a_sw_host_time: assert property ( // RULE6
    !is_hw && spectrum_send |-> $past(cnt_reg) >= $past(integ_last))
    else $error("Free-running period shorter than host time.");

  a_sw_tick_timing: assert property ( // RULE7
    !is_hw && (state_reg == ST_INTEG) && !adc_tick && !mode_chg |=> $stable(cnt_reg))
    else $error("Free-running counter moved without a converter tick.");

  a_hw_idle_wait: assert property ( // RULE9
    is_hw && (state_reg == ST_IDLE) && !trig.rise |=> !integrating && !detector_clear)
    else $error("Hardware mode left idle without an edge.");

  a_hw_clear_first: assert property ( // RULE10
    is_hw && (state_reg == ST_IDLE) && trig.rise && !mode_chg
    |=> detector_clear ##1 integrating)
    else $error("Hardware edge did not clear then integrate.");

  a_hw_fixed_length: assert property ( // RULE11
    is_hw && spectrum_send |-> $past(cnt_reg) == HW_LAST)
    else $error("Hardware period not of fixed length.");

  a_hw_send_idle: assert property ( // RULE12
    is_hw && spectrum_send |-> !integrating && (state_reg == ST_IDLE)
    ##1 (state_reg != ST_INTEG))
    else $error("Hardware mode did not return to idle after sending.");

  a_trig_mode_quiet: assert property ( // RULE13
    $rose(is_sw) |-> !spectrum_send [*2])
    else $error("Spectrum sent right after entering trigger mode.");

  // Each clear is a single cycle and never overlaps integration.
  a_clear_one_cycle: assert property ( // RULE10
    detector_clear |-> !integrating ##1 !detector_clear)
    else $error("Detector clear longer than one cycle or during integration.");

  // In hardware mode integration only starts from a clear.
  a_hw_integ_after_clear: assert property ( // RULE10
    is_hw && $rose(integrating) |-> $past(detector_clear))
    else $error("Hardware integration started without a clear.");

  // A hardware run is exactly the fixed length, whatever integ_time says.
  a_hw_run_length: assert property ( // RULE11
    is_hw && spectrum_send |-> run_len_reg == HW_LEN)
    else $error("Hardware integration run not of the fixed length.");

  // Integration in hardware mode never runs past the fixed length.
  a_hw_run_bound: assert property ( // RULE11
    is_hw && integrating |-> run_len_reg < HW_LEN)
    else $error("Hardware integration ran past the fixed length.");

  // Hardware integration is not cut short by the host time.
  a_hw_keeps_integ: assert property ( // RULE11
    is_hw && (state_reg == ST_INTEG) && !hw_done && !mode_chg |=> integrating)
    else $error("Hardware integration stopped before its end.");

  // A hardware send comes only from a completed fixed period and stands one cycle.
  a_hw_send_source: assert property ( // RULE12
    is_hw && spectrum_send |-> $past(hw_done) ##1 !spectrum_send)
    else $error("Hardware send without a completed period.");

  // An idle hardware mode produces no spectrum.
  a_hw_idle_quiet: assert property ( // RULE9
    is_hw && (state_reg == ST_IDLE) |=> !spectrum_send)
    else $error("Idle hardware mode sent a spectrum.");

  // Free-running sends fall only on a converter tick.
  a_free_send_tick: assert property ( // RULE7
    !is_hw && spectrum_send |-> $past(adc_tick))
    else $error("Free-running send not paced by a converter tick.");

  // Normal mode and the spare code both stream every period.
  a_free_send_mode: assert property ( // RULE2
    !is_sw && !is_hw && free_done && !mode_chg |=> spectrum_send)
    else $error("Normal or spare mode period ended without a spectrum.");

  // A trigger seen in software mode is kept until its period ends.
  a_sw_pend_hold: assert property ( // RULE4
    is_sw && pend_reg && !free_done && !mode_chg |=> pend_reg)
    else $error("Software trigger lost before the period end.");

  // With no trigger seen, software mode sends nothing.
  a_sw_quiet_untrig: assert property ( // RULE13
    is_sw && !pend_reg && !trig.level |=> !spectrum_send)
    else $error("Software mode sent without any trigger.");

  // Waiting is flagged while a hardware run has not been triggered.
  a_hw_wait_flag: assert property ( // RULE13
    is_hw && (state_reg == ST_IDLE) && !trig.rise && !mode_chg |=> trigger_wait)
    else $error("Idle hardware mode not flagged as waiting.");

  // Normal mode never reports waiting for a trigger.
  a_normal_no_wait: assert property ( // RULE1
    (mode_sel == MODE_NORMAL) |=> !trigger_wait)
    else $error("Normal mode flagged as waiting for a trigger.");

  // Software mode stays integrating while a trigger level is held.
  a_sw_held_integ: assert property ( // RULE5
    is_sw && integrating && trig.level && !mode_chg |=> integrating)
    else $error("Held trigger interrupted software integration.");

  c_normal_send: cover property ((mode_reg == MODE_NORMAL) && spectrum_send);
  c_sw_trig_send: cover property (is_sw && trig.rise ##[1:50] spectrum_send); // RULE8
  c_hw_cycle: cover property (is_hw && detector_clear ##1 integrating);
  c_mode_change: cover property (mode_chg && integrating);
  c_sw_held: cover property (is_sw && trig.level && spectrum_send);

endmodule // acquisition_trigger_control

// [test/trig_source.sv]
// Model of the external trigger source that drives the trigger pin.
// Assumes the bench calls its tasks from a process running on clk_sys.
`timescale 1ns/1ps
module trig_source (
  input wire logic clk_sys,
  output logic trigger_pin
);
  initial trigger_pin = 1'b0;
  task automatic set_level(input logic v);
    @(posedge clk_sys);
    trigger_pin <= v;
  endtask
  // Pulses stay high long enough for the three-stage synchroniser.
  task automatic pulse(input int n);
    set_level(1'b1);
    repeat (n) @(posedge clk_sys);
    trigger_pin <= 1'b0;
  endtask
endmodule // trig_source

// [test/acquisition_trigger_control_tb.sv]
// Self-checking bench for the acquisition trigger controller in all three modes.
// Assumes the trig_source model drives the pin and a short hardware period.
`timescale 1ns/1ps
module acquisition_trigger_control_tb;
  import acq_pkg::*;
  localparam int unsigned HW_CYC = 20;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic trigger_pin;
  logic [1:0] mode_sel = MODE_NORMAL;
  logic [INTEG_W-1:0] integ_time = 16'h0002;
  logic adc_tick = 1'b0;
  logic detector_clear, integrating, spectrum_send, trigger_wait;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 32'h0CBD;
  int per_ticks = 0;
  int sends = 0;
  int s0, cnt, w;
  bit per_chk = 0;
  bit per_first = 1;
  bit tick_hold = 0;
  always #2 clk_sys = ~clk_sys;
  trig_source src (.clk_sys(clk_sys), .trigger_pin(trigger_pin));
  acquisition_trigger_control #(.HW_INTEG_CYCLES(HW_CYC)) dut (.clk_sys(clk_sys),
    .reset(reset), .trigger_pin(trigger_pin), .mode_sel(mode_sel), .integ_time(integ_time),
    .adc_tick(adc_tick), .detector_clear(detector_clear), .integrating(integrating),
    .spectrum_send(spectrum_send), .trigger_wait(trigger_wait));
  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_num(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      n_errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  function automatic int period_ticks(input logic [INTEG_W-1:0] t);
    return (t == 0) ? 1 : int'(t);
  endfunction
  always @(posedge clk_sys) begin
    adc_tick <= !reset && !tick_hold && (($random(seed) & 3) == 0);
  end
  // Ticks are counted per period; the first period after a restart is partial.
  always @(posedge clk_sys) begin
    if (per_chk) begin
      check_bit("integrating free run", 1'b1, integrating);
    end
    if (spectrum_send === 1'b1) begin
      sends <= sends + 1;
      if (per_chk && !per_first) begin
        check_num("ticks per period", period_ticks(integ_time), per_ticks);
      end
      if (per_chk) begin
        per_first <= 1'b0;
      end
      per_ticks <= int'(adc_tick);
    end else begin
      per_ticks <= per_ticks + int'(adc_tick);
    end
  end
  task automatic enter(input logic [1:0] m, input logic [INTEG_W-1:0] t);
    per_chk <= 1'b0;
    mode_sel <= m;
    integ_time <= t;
    repeat (6) @(posedge clk_sys);
    s0 = sends;
  endtask
  task automatic watch(input int n);
    per_first <= 1'b1;
    per_chk <= 1'b1;
    repeat (n) @(posedge clk_sys);
    per_chk <= 1'b0;
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    for (int m = 0; m < 4; m += 3) begin
      enter(m[1:0], 16'($random(seed) & 3));
      watch(300);
      check_bit("normal streaming", 1'b1, sends - s0 > 3);
      check_bit("no wait in normal", 1'b0, trigger_wait);
      $display("normal test done, mode %0d", m);
    end
    enter(MODE_SW_TRIG, 16'h0008);
    watch(300);
    check_num("sends without trigger", 0, sends - s0);
    check_bit("waiting for trigger", 1'b1, trigger_wait);
    // Ticks pause while the level is high, so one pulse cannot straddle a period end.
    tick_hold <= 1'b1;
    src.pulse(4);
    repeat (8) @(posedge clk_sys);
    tick_hold <= 1'b0;
    repeat (300) @(posedge clk_sys);
    check_num("sends per trigger", 1, sends - s0);
    check_bit("wait after send", 1'b1, trigger_wait);
    src.set_level(1'b1);
    watch(400);
    check_bit("held trigger streams", 1'b1, sends - s0 > 4);
    src.set_level(1'b0);
    $display("software trigger test done");
    enter(MODE_HW_TRIG, 16'($random(seed) & 3));
    repeat (60) @(posedge clk_sys);
    check_bit("hw idle", 1'b0, integrating);
    check_num("hw sends before edge", 0, sends - s0);
    for (int k = 0; k < 3; k++) begin
      src.pulse(4);
      w = 0;
      do begin
        @(posedge clk_sys);
        w++;
      end while (detector_clear !== 1'b1 && w < 20);
      check_bit("detector clear", 1'b1, detector_clear);
      check_bit("clear before integrate", 1'b0, integrating);
      if (k == 1) begin
        fork
          src.pulse(4);
        join_none
      end
      @(posedge clk_sys);
      cnt = 0;
      while (integrating === 1'b1 && cnt < 100) begin
        cnt++;
        @(posedge clk_sys);
      end
      check_num("hw integration cycles", HW_CYC, cnt);
      check_bit("hw send at end", 1'b1, spectrum_send);
      @(posedge clk_sys);
      check_bit("hw back to idle", 1'b1, trigger_wait);
      repeat (10) @(posedge clk_sys);
    end
    repeat (60) @(posedge clk_sys);
    check_num("hw sends", 3, sends - s0);
    $display("hardware trigger test done");
    wrap_up();
  end
  initial begin
    #40000;
    n_errors++;
    wrap_up();
  end
endmodule // acquisition_trigger_control_tb
